// >>> include/dmrs_params.svh
// constants for the dma request sampling and reload block
// assumes the including file is compiled after dmrs_pkg
`ifndef DMRS_PARAMS_SVH
`define DMRS_PARAMS_SVH

// register byte offsets on the ahb-lite slave
`define DMRS_OFF_OPER   8'h00
`define DMRS_OFF_CH2    8'h04
`define DMRS_OFF_SRC    8'h08
`define DMRS_OFF_DST    8'h0C
`define DMRS_OFF_COUNT  8'h10
`define DMRS_OFF_STAT   8'h14

// field positions
`define DMRS_OPER_GEN_BIT   0
`define DMRS_OPER_NMI_BIT   1
`define DMRS_OPER_AE_BIT    2
`define DMRS_CH_CTRL_W      11
`define DMRS_CH_END_BIT     11

// reset values
`define DMRS_OPER_RST   3'h0
`define DMRS_CH_RST     11'h600
`define DMRS_ADDR_RST   32'h0000_0000
`define DMRS_COUNT_RST  32'h0000_0000

// timing: request-to-cycle latency in states, one state per clock
`define DMRS_REQ_LATENCY_STATES 3
`define DMRS_CLKS_PER_STATE     1
`define DMRS_RELOAD_UNITS       4

`endif

// >>> include/dmrs_pkg.sv
// types shared by the dma request sampling and reload block
// assumes nothing beyond a systemverilog compiler
package dmrs_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DUMMY,
        ST_XFER,
        ST_GAP
    } dmrs_state_t;

    // register selector from the address decode
    typedef enum logic [2:0] {
        SEL_OPER,
        SEL_CH,
        SEL_SRC,
        SEL_DST,
        SEL_COUNT,
        SEL_STAT,
        SEL_NONE
    } dmrs_sel_t;

    // channel 2 control word as written by software
    typedef struct packed {
        logic [2:0] bus_states;     // clocks per bus cycle, 0 means 1
        logic [1:0] unit_size;      // 0 byte, 1 half, 2/3 word
        logic       single_addr;
        logic       burst_mode;
        logic       edge_mode;
        logic       end_irq_enable;
        logic       reload_enable;
        logic       channel_enable;
    } dmrs_ch_ctrl_t;

    // global operation flags
    typedef struct packed {
        logic addr_error_flag;
        logic nmi_flag;
        logic global_dma_enable;
    } dmrs_oper_t;

endpackage

// >>> design/dmrs_top.sv
// request front end and channel 2 reload sequencer of the dma engine
// assumes an ahb-lite master on hclk and a request pin synchronous to hclk
//
// Overview of operation
// - each dma bus cycle lasts the programmed number of bus states
// - request pin detected on falling edge or low level per channel
// - first bus cycle starts no sooner than three states after detection
// - burst single-address mode issues one dummy cycle, not counted
// - dummy cycle: data undefined, no acknowledge, counter unchanged
// - later samples taken at start of cycle before the triggered transfer
// - no request at that point: sample every following cycle
// - request accept strobe pulses once per accepted sample
// - cycle steal uses the same sampling for every address/detect mode
// - single address: acknowledge held through each real transfer cycle
// - burst level: transfers continue back to back while request active
// - burst single level: dummy cycle is skipped when placing next sample
// - no dummy while continuously sampled; fresh dummy after interruption
// - burst edge: sampled once, transfers until count exhausted
// - resumed edge burst single: one strobe then one dummy cycle
// - reload enabled: source address restored every four transfer units
// - reload works for 8, 16 and 32 bit units
// - transfer count decremented by one per completed unit
// - reload counter cleared on stop events; address/count kept
// - count reaching zero sets end flag; interrupt if enabled
// - nmi or address error sets flag, stops after current transfer
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dmrs_params.svh"

module dmrs_top
    import dmrs_pkg::*;
#(
    parameter int unsigned REQ_LATENCY  = `DMRS_REQ_LATENCY_STATES,
    parameter int unsigned RELOAD_UNITS = `DMRS_RELOAD_UNITS
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        xfer_request_n,
    input  wire logic        nmi_event,
    input  wire logic        addr_error_event,
    input  wire logic        standby,
    output logic             request_accept_strobe,
    output logic             xfer_acknowledge,
    output logic             dma_cycle,
    output logic             dummy_cycle,
    output logic      [31:0] bus_address,
    output logic      [31:0] dest_address,
    output logic             end_irq
);

    localparam int REQ_CYCLES = REQ_LATENCY * `DMRS_CLKS_PER_STATE;
    localparam int RW = (RELOAD_UNITS > 2) ? $clog2(RELOAD_UNITS) : 1;

    // register decode, shared by the read and write paths
    function automatic dmrs_sel_t reg_decode(input logic [7:0] a);
        case (a)
            `DMRS_OFF_OPER:  reg_decode = SEL_OPER;
            `DMRS_OFF_CH2:   reg_decode = SEL_CH;
            `DMRS_OFF_SRC:   reg_decode = SEL_SRC;
            `DMRS_OFF_DST:   reg_decode = SEL_DST;
            `DMRS_OFF_COUNT: reg_decode = SEL_COUNT;
            `DMRS_OFF_STAT:  reg_decode = SEL_STAT;
            default:         reg_decode = SEL_NONE;
        endcase
    endfunction

    dmrs_state_t    state_reg;
    dmrs_state_t    state_next;
    dmrs_oper_t     oper_reg;
    dmrs_ch_ctrl_t  ch_reg;
    logic           end_flag_reg;
    logic [31:0]    src_reg;
    logic [31:0]    src_init_reg;
    logic [31:0]    dst_reg;
    logic [31:0]    count_reg;
    logic [RW-1:0]  reload_cnt_reg;
    logic [2:0]     cyc_cnt_reg;
    logic           req_prev_reg;
    logic           edge_pend_reg;
    logic           sampled_reg;
    logic           wr_pend_reg;
    logic           rd_wait_reg;
    logic [7:0]     addr_reg;
    logic [31:0]    hrdata_reg;
    logic           accept;
    logic           wr_en;
    dmrs_sel_t      wr_sel;

    // bus slave: writes take zero waits, reads one wait so hrdata is a flop
    wire ap_valid = hsel & htrans[1] & hready;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= ap_valid & hwrite;
            rd_wait_reg <= ap_valid & ~hwrite;
            if (ap_valid)
                addr_reg <= haddr[7:0];
        end
    end

    assign wr_en     = wr_pend_reg;
    assign wr_sel    = reg_decode(addr_reg);
    assign hreadyout = ~rd_wait_reg;
    assign hresp     = 1'b0;    // always okay, unmapped reads give zero
    assign hrdata    = hrdata_reg;

    // read data captured in the wait cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h0000_0000;
        else if (rd_wait_reg)
        begin
            case (reg_decode(addr_reg))
                SEL_OPER:  hrdata_reg <= {29'h0, oper_reg};
                SEL_CH:    hrdata_reg <= {20'h0, end_flag_reg, ch_reg};
                SEL_SRC:   hrdata_reg <= src_reg;
                SEL_DST:   hrdata_reg <= dst_reg;
                SEL_COUNT: hrdata_reg <= count_reg;
                SEL_STAT:  hrdata_reg <= {24'h0, 1'b0, state_reg,
                                          3'(reload_cnt_reg), edge_pend_reg};
                default:   hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // cycle timing derived from the programmed bus state count
    wire [2:0] cycle_len = (ch_reg.bus_states == 3'h0) ? 3'h1
                                                       : ch_reg.bus_states;
    wire cyc_first = (cyc_cnt_reg == 3'h0);
    wire cyc_last  = (cyc_cnt_reg == cycle_len - 3'h1);
    wire edge_burst = ch_reg.burst_mode & ch_reg.edge_mode;
    // the raw events count too, so a cycle that ends together with the
    // event is the last one; the flag alone would let one more unit start
    wire stop = ~oper_reg.global_dma_enable | ~ch_reg.channel_enable
              | oper_reg.nmi_flag | oper_reg.addr_error_flag
              | nmi_event | addr_error_event;
    wire go = ~stop & (count_reg != 32'h0);
    wire fall = req_prev_reg & ~xfer_request_n;
    wire detect = ch_reg.edge_mode ? (edge_pend_reg | fall)
                                   : ~xfer_request_n;
    wire xfer_end = (state_reg == ST_XFER) & cyc_last;
    wire last_unit = (count_reg == 32'h1);

    // sequencer: idle sampling, latency wait, dummy, transfer, cpu gap
    always_comb
    begin
        state_next = state_reg;
        accept     = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (go && detect)
                begin
                    accept     = 1'b1;
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (stop)
                    state_next = ST_IDLE;
                else if (cyc_cnt_reg == 3'(REQ_CYCLES - 1))
                    state_next = (ch_reg.burst_mode && ch_reg.single_addr)
                               ? ST_DUMMY : ST_XFER;
            end
            ST_DUMMY:
            begin
                if (cyc_last)
                    state_next = stop ? ST_IDLE : ST_XFER;
            end
            ST_XFER:
            begin
                // sample at the start of the cycle ahead of the next
                // transfer; the dummy cycle never hosts a sample
                if (cyc_first && !edge_burst && !last_unit && detect)
                    accept = 1'b1;
                if (cyc_last)
                begin
                    if (stop || last_unit)
                        state_next = ST_IDLE;
                    else if (edge_burst)
                        state_next = ST_XFER;
                    else if (sampled_reg || accept)
                        state_next = ch_reg.burst_mode ? ST_XFER
                                                       : ST_GAP;
                    else
                        state_next = ST_IDLE;
                end
            end
            ST_GAP:
            begin
                if (cyc_last)
                    state_next = stop ? ST_IDLE : ST_XFER;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // state and intra-cycle clock count
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg   <= ST_IDLE;
            cyc_cnt_reg <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
            // the wait counts clocks, so a short bus cycle must not wrap it
            if (state_next != state_reg || (cyc_last && state_reg != ST_WAIT))
                cyc_cnt_reg <= 3'h0;
            else
                cyc_cnt_reg <= cyc_cnt_reg + 3'h1;
        end
    end

    // sample memory within a transfer cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sampled_reg <= 1'b0;
        else if (state_reg == ST_XFER && cyc_last)
            sampled_reg <= 1'b0;
        else if (accept && state_reg == ST_XFER)
            sampled_reg <= 1'b1;
    end

    // falling edge memory; edges seen inside an edge burst are dropped so
    // a halted burst needs a fresh edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_prev_reg  <= 1'b1;
            edge_pend_reg <= 1'b0;
        end
        else
        begin
            req_prev_reg <= xfer_request_n;
            // an accept consumes the edge that caused it; a kept copy
            // would restart the channel as soon as a new count is written
            if (accept)
                edge_pend_reg <= 1'b0;
            else if (fall && ch_reg.edge_mode
                     && !(edge_burst && state_reg != ST_IDLE))
                edge_pend_reg <= 1'b1;
        end
    end

    // global flags: hardware set wins over a software write of zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            oper_reg <= dmrs_oper_t'(`DMRS_OPER_RST);
        else
        begin
            if (wr_en && wr_sel == SEL_OPER)
                oper_reg <= dmrs_oper_t'(hwdata[2:0]);
            if (nmi_event)
                oper_reg.nmi_flag <= 1'b1;
            if (addr_error_event)
                oper_reg.addr_error_flag <= 1'b1;
        end
    end

    // channel control and end flag, set wins over clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ch_reg       <= dmrs_ch_ctrl_t'(`DMRS_CH_RST);
            end_flag_reg <= 1'b0;
        end
        else
        begin
            if (wr_en && wr_sel == SEL_CH)
            begin
                ch_reg       <= dmrs_ch_ctrl_t'(hwdata[`DMRS_CH_CTRL_W-1:0]);
                end_flag_reg <= hwdata[`DMRS_CH_END_BIT];
            end
            if (xfer_end && last_unit)
                end_flag_reg <= 1'b1;
        end
    end

    // transfer count: one down per completed unit, dummies excluded
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count_reg <= `DMRS_COUNT_RST;
        else if (wr_en && wr_sel == SEL_COUNT)
            count_reg <= hwdata;
        else if (xfer_end)
            count_reg <= count_reg - 32'h1;
    end

    // reload counter cleared by any stop event; registers untouched
    wire reload_clear = ~oper_reg.global_dma_enable | ~ch_reg.channel_enable
                      | (xfer_end & last_unit) | nmi_event
                      | addr_error_event | standby;
    wire reload_wrap = (reload_cnt_reg == RW'(RELOAD_UNITS - 1));
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            reload_cnt_reg <= '0;
        else if (reload_clear)
            reload_cnt_reg <= '0;
        else if (xfer_end && ch_reg.reload_enable)
            reload_cnt_reg <= reload_wrap ? '0 : reload_cnt_reg + RW'(1);
    end

    // source address steps by the unit size, any of the three widths
    wire [31:0] unit_step = (ch_reg.unit_size == 2'h0) ? 32'h1 :
                            (ch_reg.unit_size == 2'h1) ? 32'h2 : 32'h4;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            src_reg      <= `DMRS_ADDR_RST;
            src_init_reg <= `DMRS_ADDR_RST;
            dst_reg      <= `DMRS_ADDR_RST;
        end
        else
        begin
            if (wr_en && wr_sel == SEL_SRC)
            begin
                src_reg      <= hwdata;
                src_init_reg <= hwdata;
            end
            else if (xfer_end)
            begin
                // the fourth unit reloads even when the run ends on it
                if (ch_reg.reload_enable && reload_wrap)
                    src_reg <= src_init_reg;
                else
                    src_reg <= src_reg + unit_step;
            end
            if (wr_en && wr_sel == SEL_DST)
                dst_reg <= hwdata;
        end
    end

    // pin-side outputs; acknowledge only on real single-address transfers
    assign request_accept_strobe = accept;
    assign xfer_acknowledge = (state_reg == ST_XFER)
                            & ch_reg.single_addr;
    assign dma_cycle   = (state_reg == ST_XFER) | (state_reg == ST_DUMMY);
    assign dummy_cycle = (state_reg == ST_DUMMY);
    assign bus_address  = src_reg;
    assign dest_address = dst_reg;
    assign end_irq = end_flag_reg & ch_reg.end_irq_enable;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_latency;
        (state_reg == ST_WAIT) [*3];
    endsequence

    sequence s_first_cycle;
        (state_reg == ST_DUMMY) || (state_reg == ST_XFER)
            || (state_reg == ST_IDLE);
    endsequence

    a_req_latency: assert property (
        (state_reg == ST_IDLE && accept && !stop) |=> s_latency
            ##1 s_first_cycle)
        else $error("bus cycle began before three states");

    a_dummy_quiet: assert property (
        (dummy_cycle && !wr_en) |-> !xfer_acknowledge
            ##1 (count_reg == $past(count_reg)))
        else $error("dummy cycle touched count or acknowledge");

    a_dummy_follows: assert property (
        $rose(dummy_cycle) |-> $past(state_reg) == ST_WAIT
            && ch_reg.burst_mode && ch_reg.single_addr)
        else $error("dummy cycle not at start of burst single");

    a_count_step: assert property (
        (xfer_end && !wr_en) |=> count_reg == $past(count_reg) - 32'h1)
        else $error("transfer count not decremented by one");

    a_reload_four: assert property (
        (xfer_end && ch_reg.reload_enable && reload_wrap
            && !wr_en) |=> src_reg == $past(src_init_reg))
        else $error("source address not reloaded after four units");

    a_reload_cleared: assert property (
        reload_clear |=> reload_cnt_reg == '0)
        else $error("reload counter survived a stop event");

    a_end_flag_set: assert property (
        (xfer_end && last_unit) |=> end_flag_reg && count_reg == 32'h0)
        else $error("end flag not set when count ran out");

    a_nmi_halts: assert property (
        nmi_event |=> oper_reg.nmi_flag ##0
            (state_reg != ST_XFER || !$past(cyc_last)
                || $past(state_reg) != ST_XFER))
        else $error("nmi did not set flag or stop transfers");

    a_edge_once: assert property (
        (state_reg == ST_XFER && edge_burst) |-> !request_accept_strobe)
        else $error("edge burst sampled the request again");

    a_idle_sample: assert property (
        (state_reg == ST_IDLE && go && detect) |-> request_accept_strobe
            ##1 state_reg == ST_WAIT)
        else $error("pending request not accepted while idle");

    a_ack_window: assert property (
        $rose(xfer_acknowledge) |-> xfer_acknowledge [*1]
            ##0 (cycle_len != 3'h1 || xfer_end))
        else $error("acknowledge not aligned with transfer cycle");

endmodule
`default_nettype wire

// >>> verif/dmrs_req_model.sv
// requesting peripheral model: drives the active-low request pin
// assumes hold and fire come from the bench, changed after hclk edges
`timescale 1ns/1ps
`default_nettype none
module dmrs_req_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic hold,
    input  wire logic fire,
    output logic      xfer_request_n
);
    logic [1:0] pulse_reg;

    // fire makes a fresh falling edge held two clocks; a halted edge
    // burst only resumes on such a new edge, never on a stale low pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pulse_reg <= 2'h0;
        else if (fire)
            pulse_reg <= 2'h2;
        else if (pulse_reg != 2'h0)
            pulse_reg <= pulse_reg - 2'h1;
    end

    // level request while hold; released pin goes to its pull-up level
    assign xfer_request_n = !(hold || pulse_reg != 2'h0);
endmodule
`default_nettype wire

// >>> verif/tb_dma_request_sampling_reload.sv
// self-checking bench for the request front end and channel 2 reload
// assumes dmrs_top as the only ahb-lite slave and one requester model
`timescale 1ns/1ps
`default_nettype none
`include "dmrs_params.svh"
module tb_dma_request_sampling_reload;
    logic        hclk = 0;
    logic        hresetn = 0;
    logic        hsel = 0;
    logic        hwrite = 0;
    logic        hold = 0;
    logic        fire = 0;
    logic        nmi = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] rd;
    logic [10:0] ch;
    wire logic [31:0] hrdata;
    wire logic [31:0] bus_address;
    wire logic [31:0] dst;
    wire logic   hresp;
    wire logic   hreadyout;
    wire logic   strobe;
    wire logic   ack;
    wire logic   dma;
    wire logic   dummy;
    wire logic   end_irq;
    wire logic   req_n;
    logic        dma_q = 0;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_str, n_dum, n_ack, lat, cyc, t0, left;
    // config, count and expected strobes, dummy and ack clocks
    localparam logic [10:0] CH [6] =
        '{11'h135, 11'h13D, 11'h125, 11'h105, 11'h115, 11'h225};
    localparam int CNT [6] = '{4, 4, 2, 2, 4, 2};
    localparam int E_STR [6] = '{4, 1, 2, 2, 4, 2};
    localparam int E_DUM [6] = '{1, 1, 0, 0, 0, 0};
    localparam int E_ACK [6] = '{4, 4, 2, 0, 0, 4};

    always #5 hclk = ~hclk;

    dmrs_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .xfer_request_n(req_n),
        .nmi_event(nmi), .addr_error_event(1'b0), .standby(1'b0),
        .request_accept_strobe(strobe), .xfer_acknowledge(ack),
        .dma_cycle(dma), .dummy_cycle(dummy), .bus_address(bus_address),
        .dest_address(dst), .end_irq(end_irq)
    );

    dmrs_req_model peer (
        .hclk(hclk), .hresetn(hresetn), .hold(hold), .fire(fire),
        .xfer_request_n(req_n)
    );

    // monitor on the falling edge, where outputs have settled
    always @(negedge hclk)
    begin
        cyc++;
        if (strobe === 1'b1) n_str++;
        if (dummy === 1'b1) n_dum++;
        if (ack === 1'b1) n_ack++;
        if (strobe === 1'b1 && dma !== 1'b1) t0 = cyc;
        if (dma === 1'b1 && dma_q !== 1'b1 && lat < 0) lat = cyc - t0;
        dma_q = dma;
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // bounded wait until hready will be seen high at the next edge
    task automatic wait_rdy;
        int i;
        i = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && i < 50)
        begin
            @(negedge hclk);
            i++;
        end
        if (i == 50)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // one single word transfer; entered and left just after an edge
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        @(posedge hclk);
    endtask

    // bounded wait for a stop or end condition
    task automatic wait_for(input bit on_end);
        int i;
        for (i = 0; i < 500; i++)
        begin
            @(negedge hclk);
            if (on_end ? end_irq === 1'b1 : dma === 1'b0) break;
        end
        if (i == 500)
        begin
            n_mismatch++;
            end_sim();
        end
        @(posedge hclk);
    endtask

    // program source and count, then enable and raise the request
    task automatic start(input logic [10:0] c, input int cnt);
        ahb(1, 8'h08, 32'h0000_0100);
        ahb(1, 8'h0C, 32'h0000_0200);
        ahb(1, 8'h10, cnt);
        n_str = 0;
        n_dum = 0;
        n_ack = 0;
        lat = -1;
        ahb(1, 8'h04, {21'h0, c});
        if (c[3]) fire <= 1'b1;
        else hold <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
    endtask

    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, 8'h04, 0);
        check("ch2 reset", 32'h0000_0600, rd);
        ahb(0, 8'h00, 0);
        check("oper reset", 32'h0000_0000, rd);
        ahb(0, 8'h20, 0);
        check("unmapped read", 32'h0000_0000, rd);
        check("hresp", 0, hresp);
        ahb(1, 8'h00, 32'h0000_0001);
        // every bus mode, address mode and detection method
        for (int k = 0; k < 6; k++)
        begin
            start(CH[k], CNT[k]);
            wait_for(1);
            hold <= 1'b0;
            check("strobes", E_STR[k], n_str);
            check("dummy clocks", E_DUM[k], n_dum);
            check("ack clocks", E_ACK[k], n_ack);
            check("latency", `DMRS_REQ_LATENCY_STATES + 1, lat);
            ahb(0, 8'h10, 0);
            check("count", 0, rd);
            check("dest addr", 32'h0000_0200, dst);
            ahb(0, 8'h04, 0);
            check("end flag", 1, rd[11]);
        end
        // reload on for each unit size, then off as reference
        for (int u = 0; u < 4; u++)
        begin
            ch = 11'h115 | (u < 3 ? 11'h2 : 11'h0) | (11'(u % 3) << 6);
            start(ch, 8);
            wait_for(1);
            hold <= 1'b0;
            check("src after run",
                  u < 3 ? 32'h100 : 32'h108, bus_address);
            ahb(0, 8'h10, 0);
            check("count reload", 0, rd);
        end
        // stop an edge burst by nmi, then resume with a new edge
        start(11'h13D, 8);
        for (int i = 0; i < 100 && n_ack < 2; i++) @(posedge hclk);
        nmi <= 1'b1;
        @(posedge hclk);
        nmi <= 1'b0;
        wait_for(0);
        left = 8 - n_ack;
        ahb(0, 8'h00, 0);
        check("nmi flag", 1, rd[1]);
        ahb(0, 8'h10, 0);
        check("count at stop", left, rd);
        ahb(1, 8'h00, 32'h0000_0001);
        n_str = 0;
        n_dum = 0;
        n_ack = 0;
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        wait_for(1);
        check("resume strobes", 1, n_str);
        check("resume dummy", 1, n_dum);
        check("resume acks", left, n_ack);
        end_sim();
    end
endmodule
`default_nettype wire
